//--- ccl_pkg.sv
package ccl_pkg;
  // ******************************************
  // Register indices, byte address = 4 * index
  // ******************************************
  localparam logic [7:0] IDX_DIG_DIS = 8'h0d;
  localparam logic [7:0] IDX_CTRL_B = 8'h13;
  localparam logic [7:0] IDX_CTRL_STAT = 8'h14;
  localparam logic [7:0] IDX_INT_STAT = 8'h20;
  localparam logic [7:0] IDX_INT_MASK = 8'h21;
  localparam int IDX_SHIFT = 2;

  // ******************************************
  // Control/status field positions
  // ******************************************
  localparam int CS_POWER_OFF = 7;
  localparam int CS_BANDGAP = 6;
  localparam int CS_OUT_SYNC = 5;
  localparam int CS_IRQ_FLAG = 4;
  localparam int CS_IRQ_EN = 3;
  localparam int CS_CAPTURE = 2;
  localparam int CS_MODE_HI = 1;
  localparam int CS_MODE_LO = 0;

  localparam int CB_HYST_SEL = 7;
  localparam int CB_HYST_LEV = 6;
  localparam int CB_RSVD_A = 5;
  localparam int CB_ZERO = 4;
  localparam int CB_RSVD_B = 3;
  localparam int CB_MUX_EN = 2;
  localparam int CB_RSVD_C = 1;
  localparam int CB_RSVD_D = 0;

  localparam int IS_EDGE = 0;
  localparam int IS_TOGGLE = 1;
  localparam int INT_BITS = 2;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] CB_WMASK = 8'hef;
  localparam logic [7:0] CS_WMASK = 8'hcf;

  // ******************************************
  // Interrupt mode field and channel limits
  // ******************************************
  localparam logic [1:0] MODE_TOGGLE = 2'h0;
  localparam logic [1:0] MODE_RSVD = 2'h1;
  localparam logic [1:0] MODE_FALL = 2'h2;
  localparam logic [1:0] MODE_RISE = 2'h3;
  localparam logic [3:0] CHAN_MAX = 4'hb;

  localparam int HYST_LOW_MV = 20;
  localparam int HYST_HIGH_MV = 50;
endpackage : ccl_pkg

//--- ccl_comparator_ctrl.sv
// The APB interface to the registers was left to the implementer.
module ccl_comparator_ctrl #(
  parameter int ADDR_W = 8,
  parameter int PIN_W = 8
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic cmp_raw_in,
  input wire logic global_irq_enable_in,
  input wire logic irq_vector_ack_in,
  input wire logic converter_enable_in,
  input wire logic [3:0] converter_channel_select_in,
  input wire logic [PIN_W-1:0] pin_level_in,
  output logic cmp_irq_req_out,
  output logic capture_trigger_out,
  output logic neg_from_mux_out,
  output logic neg_from_pin_out,
  output logic [3:0] neg_channel_out,
  output logic hyst_enable_out,
  output logic hyst_level_out,
  output logic cmp_power_off_out,
  output logic bandgap_select_out,
  output logic [PIN_W-1:0] dig_buf_disable_out,
  output logic [PIN_W-1:0] pin_readback_out,
  output logic irq_out
);
  import ccl_pkg::*;

  // ******************************************
  // Address decode
  // ******************************************
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = 8'(addr >> IDX_SHIFT);
  endfunction

  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx == IDX_DIG_DIS) || (idx == IDX_CTRL_B) ||
                (idx == IDX_CTRL_STAT) || (idx == IDX_INT_STAT) ||
                (idx == IDX_INT_MASK);
  endfunction

  logic [7:0] acc_idx;
  logic word_aligned;
  logic acc_hit;
  logic wr_fire;
  logic rd_fire;
  logic lane0;

  assign acc_idx = reg_index(paddr_in);
  assign word_aligned = (paddr_in[IDX_SHIFT-1:0] == '0);
  assign acc_hit = word_aligned && is_mapped(acc_idx);
  // One wait state: pready rises in the second access cycle
  assign wr_fire = psel_in && penable_in && pready_out && pwrite_in;
  assign rd_fire = psel_in && penable_in && !pready_out && !pwrite_in;
  assign lane0 = pstrb_in[0];

  // ******************************************
  // Register storage
  // ******************************************
  logic [7:0] dig_dis_ff;
  logic [7:0] ctrl_b_ff;
  logic [7:0] ctrl_s_ff;
  logic irq_flag_ff;
  logic [INT_BITS-1:0] int_stat_ff;
  logic [INT_BITS-1:0] int_mask_ff;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dig_dis_ff <= RST_BYTE;
    end else if (wr_fire && lane0 && acc_hit && acc_idx == IDX_DIG_DIS) begin
      dig_dis_ff <= pwdata_in[7:0];
    end
  end

  // Reserved bits store what software writes; bit 4 never stores
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_b_ff <= RST_BYTE;
    end else if (wr_fire && lane0 && acc_hit && acc_idx == IDX_CTRL_B) begin
      ctrl_b_ff <= pwdata_in[7:0] & CB_WMASK;
    end
  end

  // Flag and output bits live elsewhere, masked out here
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_s_ff <= RST_BYTE;
    end else if (wr_fire && lane0 && acc_hit && acc_idx == IDX_CTRL_STAT) begin
      ctrl_s_ff <= pwdata_in[7:0] & CS_WMASK;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      int_mask_ff <= '0;
    end else if (wr_fire && lane0 && acc_hit && acc_idx == IDX_INT_MASK) begin
      int_mask_ff <= pwdata_in[INT_BITS-1:0];
    end
  end

  // ******************************************
  // Comparator output synchroniser
  // ******************************************
  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= cmp_raw_in;
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= sync2_ff;
    end
  end

  // ******************************************
  // Event detection
  // ******************************************
  logic rise_evt;
  logic fall_evt;
  logic toggle_evt;
  logic mode_evt;
  logic [1:0] irq_mode;

  assign rise_evt = sync2_ff && !prev_ff;
  assign fall_evt = !sync2_ff && prev_ff;
  assign toggle_evt = rise_evt || fall_evt;
  assign irq_mode = {ctrl_s_ff[CS_MODE_HI], ctrl_s_ff[CS_MODE_LO]};

  // Mode changes are not guarded; a spurious event is possible
  always_comb begin
    case (irq_mode)
      MODE_TOGGLE: mode_evt = toggle_evt;
      MODE_RSVD: mode_evt = 1'b0;
      MODE_FALL: mode_evt = fall_evt;
      MODE_RISE: mode_evt = rise_evt;
      default: mode_evt = 1'b0;
    endcase
  end

  // ******************************************
  // Comparator interrupt flag
  // ******************************************
  logic flag_clr;

  assign flag_clr = irq_vector_ack_in ||
                    (wr_fire && lane0 && acc_hit && acc_idx == IDX_CTRL_STAT &&
                     pwdata_in[CS_IRQ_FLAG]);

  // Set wins over a clear in the same cycle
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_flag_ff <= 1'b0;
    end else if (mode_evt) begin
      irq_flag_ff <= 1'b1;
    end else if (flag_clr) begin
      irq_flag_ff <= 1'b0;
    end
  end

  // ******************************************
  // Sticky status for the block interrupt line
  // ******************************************
  logic [INT_BITS-1:0] int_evt;
  logic [INT_BITS-1:0] int_clr;

  always_comb begin
    int_evt = '0;
    int_evt[IS_EDGE] = mode_evt;
    int_evt[IS_TOGGLE] = toggle_evt;
    int_clr = '0;
    if (wr_fire && lane0 && acc_hit && acc_idx == IDX_INT_STAT) begin
      int_clr = pwdata_in[INT_BITS-1:0];
    end
  end

  generate
    for (genvar i = 0; i < INT_BITS; i++) begin : g_stat
      always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          int_stat_ff[i] <= 1'b0;
        end else if (int_evt[i]) begin
          int_stat_ff[i] <= 1'b1;
        end else if (int_clr[i]) begin
          int_stat_ff[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(int_stat_ff & int_mask_ff);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmp_irq_req_out <= 1'b0;
    end else begin
      cmp_irq_req_out <= irq_flag_ff && ctrl_s_ff[CS_IRQ_EN] &&
                         global_irq_enable_in;
    end
  end

  // ******************************************
  // Capture routing
  // ******************************************
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      capture_trigger_out <= 1'b0;
    end else if (ctrl_s_ff[CS_CAPTURE]) begin
      capture_trigger_out <= sync2_ff;
    end else begin
      capture_trigger_out <= 1'b0;
    end
  end

  // ******************************************
  // Negative input selection
  // ******************************************
  logic use_mux;

  // Codes above eleven fall back to the dedicated pin
  assign use_mux = ctrl_b_ff[CB_MUX_EN] && !converter_enable_in &&
                   (converter_channel_select_in <= CHAN_MAX);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      neg_from_mux_out <= 1'b0;
      neg_from_pin_out <= 1'b1;
      neg_channel_out <= 4'h0;
    end else begin
      neg_from_mux_out <= use_mux;
      neg_from_pin_out <= !use_mux;
      neg_channel_out <= use_mux ? converter_channel_select_in : 4'h0;
    end
  end

  // ******************************************
  // Analog settings
  // ******************************************
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hyst_enable_out <= 1'b0;
      hyst_level_out <= 1'b0;
      cmp_power_off_out <= 1'b0;
      bandgap_select_out <= 1'b0;
    end else begin
      hyst_enable_out <= ctrl_b_ff[CB_HYST_SEL];
      // Level only meaningful with hysteresis on: 0=20mV, 1=50mV
      hyst_level_out <= ctrl_b_ff[CB_HYST_SEL] && ctrl_b_ff[CB_HYST_LEV];
      cmp_power_off_out <= ctrl_s_ff[CS_POWER_OFF];
      bandgap_select_out <= ctrl_s_ff[CS_BANDGAP];
    end
  end

  // ******************************************
  // Digital input buffers and pin readback
  // ******************************************
  generate
    for (genvar p = 0; p < PIN_W; p++) begin : g_pin
      always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          dig_buf_disable_out[p] <= 1'b0;
          pin_readback_out[p] <= 1'b0;
        end else begin
          dig_buf_disable_out[p] <= dig_dis_ff[p];
          pin_readback_out[p] <= pin_level_in[p] && !dig_dis_ff[p];
        end
      end
    end
  endgenerate

  // ******************************************
  // APB read path and response
  // ******************************************
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    case (acc_idx)
      IDX_DIG_DIS: rd_byte = dig_dis_ff;
      IDX_CTRL_B: rd_byte = ctrl_b_ff & CB_WMASK;
      IDX_CTRL_STAT: begin
        rd_byte = ctrl_s_ff;
        rd_byte[CS_OUT_SYNC] = sync2_ff;
        rd_byte[CS_IRQ_FLAG] = irq_flag_ff;
      end
      IDX_INT_STAT: rd_byte[INT_BITS-1:0] = int_stat_ff;
      IDX_INT_MASK: rd_byte[INT_BITS-1:0] = int_mask_ff;
      default: rd_byte = 8'h00;
    endcase
    if (!word_aligned) begin
      rd_byte = 8'h00;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
    end else begin
      pready_out <= psel_in && penable_in && !pready_out;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pslverr_out <= 1'b0;
    end else begin
      pslverr_out <= psel_in && penable_in && !pready_out && !acc_hit;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (rd_fire) begin
      prdata_out <= {24'h00_0000, rd_byte};
    end else if (!(psel_in && penable_in)) begin
      prdata_out <= 32'h0000_0000;
    end
  end
endmodule // ccl_comparator_ctrl

//--- ccl_comparator_ctrl_sva.sv
module ccl_comparator_ctrl_sva #(
  parameter int PIN_W = 8
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic cmp_raw_in,
  input wire logic global_irq_enable_in,
  input wire logic converter_enable_in,
  input wire logic [3:0] converter_channel_select_in,
  input wire logic cmp_irq_req_out,
  input wire logic capture_trigger_out,
  input wire logic neg_from_mux_out,
  input wire logic neg_from_pin_out,
  input wire logic [3:0] neg_channel_out,
  input wire logic hyst_enable_out,
  input wire logic hyst_level_out,
  input wire logic [PIN_W-1:0] dig_buf_disable_out,
  input wire logic [PIN_W-1:0] pin_readback_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_req_global; cmp_irq_req_out |-> $past(global_irq_enable_in); endproperty
  a_req_global: assert property (p_req_global) else $error("irq request without global enable");
  property p_capture; capture_trigger_out |-> $past(cmp_raw_in, 3); endproperty
  a_capture: assert property (p_capture) else $error("capture not tied to comparator");
  property p_neg_one; neg_from_mux_out != neg_from_pin_out; endproperty
  a_neg_one: assert property (p_neg_one) else $error("negative input source not unique");
  property p_pin_chan; neg_from_pin_out |-> neg_channel_out == 4'h0; endproperty
  a_pin_chan: assert property (p_pin_chan) else $error("channel nonzero on pin path");
  property p_mux;
    neg_from_mux_out |-> !$past(converter_enable_in) && neg_channel_out <= 4'hb &&
      neg_channel_out == $past(converter_channel_select_in);
  endproperty
  a_mux: assert property (p_mux) else $error("mux path with bad channel or converter on");
  property p_hyst; !hyst_enable_out |-> !hyst_level_out; endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis level without select");
  property p_readback; (pin_readback_out & dig_buf_disable_out) == '0; endproperty
  a_readback: assert property (p_readback) else $error("disabled pin reads one");
  property p_err; pslverr_out |-> pready_out ##1 !pready_out; endproperty
  a_err: assert property (p_err) else $error("error without single ready pulse");
endmodule // ccl_comparator_ctrl_sva

bind ccl_comparator_ctrl ccl_comparator_ctrl_sva #(.PIN_W(PIN_W)) ccl_sva_i (.sys_clk_in, .rst_n_in, .pready_out,
  .pslverr_out, .cmp_raw_in, .global_irq_enable_in, .converter_enable_in, .converter_channel_select_in,
  .cmp_irq_req_out, .capture_trigger_out, .neg_from_mux_out, .neg_from_pin_out, .neg_channel_out,
  .hyst_enable_out, .hyst_level_out, .dig_buf_disable_out, .pin_readback_out);

//--- ccl_cmp_model.sv
module ccl_cmp_model (
  input wire logic sys_clk_in,
  input wire logic level_in,
  input wire logic slow_in,
  output logic cmp_raw_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic stage_ff;
  // Slow mode mimics a sluggish analog edge, one extra cycle
  always_ff @(posedge sys_clk_in) begin
    stage_ff <= level_in;
    cmp_raw_out <= slow_in ? stage_ff : level_in;
  end
endmodule // ccl_cmp_model

//--- test_comparator_control_logic.sv
module test_comparator_control_logic;
  timeunit 1ns;
  timeprecision 1ns;
  import ccl_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, gie = 0, ack = 0, cen = 0, lvl = 0, slow = 0;
  logic [7:0] paddr = '0, pins = 8'hff;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0] pstrb = '0, chan = '0, nch;
  logic pready, pslverr, raw, req, capt, nmux, npin, hen, hysteresis_level, irq, pwo, bg;
  logic [7:0] dbd, prb;
  int num_errors = 0, num_checks = 0;
  always #25 clk = ~clk;
  ccl_cmp_model ccl_cmp_model_i (.sys_clk_in(clk), .level_in(lvl), .slow_in(slow), .cmp_raw_out(raw));
  ccl_comparator_ctrl ccl_comparator_ctrl_i (.sys_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .cmp_raw_in(raw), .global_irq_enable_in(gie),
    .irq_vector_ack_in(ack), .converter_enable_in(cen), .converter_channel_select_in(chan), .pin_level_in(pins),
    .cmp_irq_req_out(req), .capture_trigger_out(capt), .neg_from_mux_out(nmux), .neg_from_pin_out(npin),
    .neg_channel_out(nch), .hyst_enable_out(hen), .hyst_level_out(hysteresis_level), .cmp_power_off_out(pwo),
    .bandgap_select_out(bg), .dig_buf_disable_out(dbd), .pin_readback_out(prb), .irq_out(irq));
  // ******************************************
  // Shared tasks
  // ******************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Master holds the request until ready is seen high at an edge
  task automatic apb(input logic [7:0] idx, input logic w, input logic [7:0] d, input logic [3:0] s,
    output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    paddr <= {idx[5:0], 2'h0};
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge clk);
    pen <= 1;
    // Only the watchdog ends a wait that never sees ready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    pen <= 0;
    chk(pready, 1);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(idx, 1, d, 4'h1, r, e);
    chk(e, 0);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(idx, 0, 8'h0, 4'h1, r, e);
    chk(r, x);
  endtask
  // ******************************************
  // Scenarios
  // ******************************************
  task automatic t_reset();
    rd(IDX_DIG_DIS, 0);
    rd(IDX_CTRL_B, 0);
    rd(IDX_CTRL_STAT, 0);
    chk({hen, capt, npin, req}, 4'h2);
  endtask
  task automatic t_ctrl_b();
    wr(IDX_CTRL_B, 8'hd4);
    rd(IDX_CTRL_B, 32'hc4);
    chk({hen, hysteresis_level}, 2'h3);
    wr(IDX_CTRL_B, 8'h80);
    cyc(2);
    chk({hen, hysteresis_level}, 2'h2);
    wr(IDX_CTRL_B, 8'h40);
    cyc(2);
    chk({hen, hysteresis_level}, 2'h0);
  endtask
  task automatic t_mux();
    wr(IDX_CTRL_B, 8'h04);
    for (int c = 0; c < 12; c++) begin
      chan <= c[3:0];
      cyc(3);
      chk({nmux, nch}, {1'b1, c[3:0]});
    end
    // Codes above eleven fall back to the dedicated pin
    chan <= 4'hc;
    cyc(3);
    chk({npin, nch}, 5'h10);
    cen <= 1;
    cyc(3);
    chk({npin, nch}, 5'h10);
    cen <= 0;
    wr(IDX_CTRL_B, 8'h00);
    cyc(2);
    chk({npin, nmux}, 2'h2);
  endtask
  task automatic t_digdis();
    logic [31:0] r;
    logic e;
    wr(IDX_DIG_DIS, 8'h06);
    apb(IDX_DIG_DIS, 1, 8'hff, 4'h0, r, e);
    cyc(2);
    chk({dbd, prb}, 16'h06f9);
    rd(IDX_DIG_DIS, 32'h06);
    apb(8'h01, 0, 8'h0, 4'h1, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
  endtask
  // Enable stays off while the mode is changed
  task automatic t_modes();
    logic [1:0] m[4] = '{MODE_TOGGLE, MODE_FALL, MODE_RISE, MODE_RSVD};
    logic [1:0] fr[4] = '{2'h3, 2'h1, 2'h2, 2'h0};
    for (int i = 0; i < 4; i++) begin
      wr(IDX_CTRL_STAT, {6'h04, m[i]});
      lvl <= 1;
      cyc(6);
      rd(IDX_CTRL_STAT, {26'h0, 1'b1, fr[i][1], 2'h0, m[i]});
      wr(IDX_CTRL_STAT, {6'h04, m[i]});
      lvl <= 0;
      cyc(6);
      rd(IDX_CTRL_STAT, {27'h0, fr[i][0], 2'h0, m[i]});
    end
  endtask
  task automatic t_irq();
    wr(IDX_CTRL_STAT, 8'h1b);
    gie <= 1;
    lvl <= 1;
    cyc(6);
    chk(req, 1);
    gie <= 0;
    cyc(2);
    chk(req, 0);
    gie <= 1;
    ack <= 1;
    cyc(1);
    ack <= 0;
    cyc(2);
    chk(req, 0);
    rd(IDX_CTRL_STAT, 32'h2b);
    wr(IDX_INT_MASK, 8'h01);
    wr(IDX_INT_STAT, 8'h03);
    lvl <= 0;
    cyc(6);
    rd(IDX_INT_STAT, 32'h02);
    chk(irq, 0);
    wr(IDX_INT_MASK, 8'h02);
    cyc(2);
    chk(irq, 1);
    wr(IDX_INT_STAT, 8'h02);
    cyc(2);
    chk(irq, 0);
  endtask
  task automatic t_capture();
    slow <= 1;
    wr(IDX_CTRL_STAT, 8'h14);
    lvl <= 1;
    cyc(7);
    chk(capt, 1);
    lvl <= 0;
    cyc(7);
    chk(capt, 0);
    wr(IDX_CTRL_STAT, 8'h10);
    lvl <= 1;
    cyc(7);
    chk(capt, 0);
    wr(IDX_CTRL_STAT, 8'hc0);
    cyc(2);
    chk({pwo, bg}, 2'h3);
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    cyc(2);
    rst_n <= 1;
    t_reset();
    t_ctrl_b();
    t_mux();
    t_digdis();
    t_modes();
    t_irq();
    t_capture();
    report_and_stop();
  end
  initial begin
    #500000;
    num_errors++;
    report_and_stop();
  end
endmodule // test_comparator_control_logic
